/* hdl/aola_pkg.sv */
// Shared constants for the actuator drive selector and limit monitor
package aola_pkg;
  // Value scale
  localparam int VAL_W = 16;
  localparam logic [15:0] VAL_CLOSED = 16'h0000; // Fully closed, 0 counts
  localparam logic [15:0] VAL_OPEN = 16'h6000; // Fully open, 24576 counts
  localparam logic [15:0] VAL_MAX = 16'h7FFF; // Largest INT, default high trip
  localparam logic [15:0] VAL_MIN = 16'h8000; // Smallest INT, default low trip
  localparam logic [15:0] SAFE_VALUE_RST = 16'h0000;

  // Force select codes
  localparam logic [7:0] FORCE_NORMAL = 8'h00;
  localparam logic [7:0] FORCE_CLOSED = 8'h01;
  localparam logic [7:0] FORCE_OPEN = 8'h02;
  localparam logic [7:0] FORCE_HOLD = 8'h03;
  localparam logic [7:0] FORCE_FALLBACK = 8'h04;
  localparam logic [7:0] FORCE_RST = 8'h00;

  // Fallback behaviour codes
  localparam logic [7:0] FALL_CLOSED = 8'h00;
  localparam logic [7:0] FALL_OPEN = 8'h01;
  localparam logic [7:0] FALL_HOLD = 8'h02;
  localparam logic [7:0] FALL_SAFE_VALUE = 8'h03;
  localparam logic [7:0] FALL_RST = 8'h00;

  // Limit flag bit positions
  localparam int FLAG_HI_ALARM = 0;
  localparam int FLAG_LO_ALARM = 1;
  localparam int FLAG_HI_WARN = 2;
  localparam int FLAG_LO_WARN = 3;

  // Service codes
  localparam logic [7:0] SVC_GET_SINGLE = 8'h0E;
  localparam logic [7:0] SVC_SET_SINGLE = 8'h10;

  // Attribute identifiers
  localparam logic [7:0] ATTR_REVISION = 8'h01;
  localparam logic [7:0] ATTR_DATA_TYPE = 8'h03;
  localparam logic [7:0] ATTR_DATA_UNITS = 8'h04;
  localparam logic [7:0] ATTR_FORCE = 8'h05;
  localparam logic [7:0] ATTR_VALUE = 8'h06;
  localparam logic [7:0] ATTR_FLAGS = 8'h07;
  localparam logic [7:0] ATTR_ALARM_EN = 8'h08;
  localparam logic [7:0] ATTR_WARN_EN = 8'h09;
  localparam logic [7:0] ATTR_ALARM_HI = 8'h0F;
  localparam logic [7:0] ATTR_ALARM_LO = 8'h10;
  localparam logic [7:0] ATTR_WARN_HI = 8'h12;
  localparam logic [7:0] ATTR_WARN_LO = 8'h13;
  localparam logic [7:0] ATTR_FALLBACK = 8'h15;
  localparam logic [7:0] ATTR_SAFE_VALUE = 8'h16;

  // Response status codes
  localparam logic [7:0] RSP_OK = 8'h00;
  localparam logic [7:0] RSP_NO_SERVICE = 8'h08;
  localparam logic [7:0] RSP_BAD_VALUE = 8'h09;
  localparam logic [7:0] RSP_NOT_SETTABLE = 8'h0E;
  localparam logic [7:0] RSP_NO_ATTR = 8'h14;
  localparam logic [7:0] RSP_NO_OBJECT = 8'h16;
endpackage

/* hdl/aola_limit_check.sv */
`timescale 1ns/1ps
// High and low trip comparison for one pair of trip points
module aola_limit_check (
  input wire logic enable_in,
  input wire logic [15:0] value_in,
  input wire logic [15:0] trip_hi_in,
  input wire logic [15:0] trip_lo_in,
  output logic over_out,
  output logic under_out
);
  // Signed compare, trip points share the INT type of the value
  function automatic logic above(input logic [15:0] a, input logic [15:0] b);
    above = $signed(a) > $signed(b);
  endfunction

  // Strictly beyond the trip point, gated by the enable
  assign over_out = enable_in && above(value_in, trip_hi_in);
  assign under_out = enable_in && above(trip_lo_in, value_in);
endmodule

/* hdl/aola_top.sv */
`timescale 1ns/1ps
// Function
// - Code 0 passes loop command through
// - Code 1 forces zero counts
// - Code 2 forces 24576 counts
// - Code 3 freezes last produced value
// - Code 4 follows fallback behaviour field
// - Reported value can be any 16-bit INT, not only 0 to 24576
// - No clamp to nominal control range
// - Flag byte bits 0-3, upper zero
// - Fallback 0 drives closed, zero counts
// - Fallback 1 drives open, 24576 counts
// - Fallback 2 holds value before entry
// - Fallback 3 drives configured safe value
// - Alarm bits set beyond alarm trips
// - Warning bits set beyond warning trips
// - Forward alarms when supervisor enables them
// - Forward warnings when supervisor enables them
// - Get service 0x0E returns attribute
// - Set service 0x10 stores attribute
// - Fallback governs code 0 and codes above 4 when not executing
// - Alarm and warning enables reset disabled
module aola_top import aola_pkg::*; #(
  parameter logic [15:0] REVISION = 16'h0001, // Arbitrary revision value
  parameter logic [15:0] DATA_TYPE_CODE = 16'h00C3, // INT type code
  parameter logic [15:0] DATA_UNITS_CODE = 16'h1001 // Counts unit code
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [15:0] loop_cmd_in, // Command from the control loop
  input wire logic executing_in, // Device is in the executing state
  input wire logic sup_alarm_en_in, // Supervisor reports alarms
  input wire logic sup_warn_en_in, // Supervisor reports warnings
  input wire logic svc_valid_in, // Service request strobe
  input wire logic [7:0] svc_code_in,
  input wire logic [7:0] svc_instance_in,
  input wire logic [7:0] svc_attr_in,
  input wire logic [15:0] svc_wdata_in,
  output logic rsp_valid_out,
  output logic [7:0] rsp_status_out,
  output logic [15:0] rsp_data_out,
  output logic [15:0] actuator_value_out,
  output logic [7:0] limit_flags_out,
  output logic exc_alarm_out,
  output logic [1:0] exc_alarm_detail_out,
  output logic exc_warn_out,
  output logic [1:0] exc_warn_detail_out
);
  // Configuration attributes
  logic [7:0] force_q; // actuator_force_select
  logic [7:0] fallback_q; // fallback_behaviour_select
  logic [15:0] safe_value_q;
  logic alarm_en_q;
  logic warn_en_q;
  logic [15:0] alarm_hi_q;
  logic [15:0] alarm_lo_q;
  logic [15:0] warn_hi_q;
  logic [15:0] warn_lo_q;
  // Block state
  logic [15:0] value_q;
  logic [15:0] value_d;
  logic [7:0] flags_q; // actuator_limit_flags
  logic [7:0] flags_d;
  logic rsp_valid_q;
  logic [7:0] rsp_status_q;
  logic [15:0] rsp_data_q;
  logic exc_alarm_q;
  logic exc_warn_q;
  logic [1:0] exc_alarm_det_q;
  logic [1:0] exc_warn_det_q;

  // Force code decode; codes above 4 count as normal
  wire force_closed = force_q == FORCE_CLOSED;
  wire force_open = force_q == FORCE_OPEN;
  wire force_hold = force_q == FORCE_HOLD;
  wire force_fall = force_q == FORCE_FALLBACK;
  wire force_none = !(force_closed || force_open || force_hold || force_fall);
  // Fallback applies when asked for, or when idle outside executing
  wire use_fallback = force_fall || (force_none && !executing_in);

  // Fallback behaviour; an unknown code keeps the closed default
  wire [15:0] fallback_val =
    (fallback_q == FALL_OPEN) ? VAL_OPEN :
    (fallback_q == FALL_HOLD) ? value_q :
    (fallback_q == FALL_SAFE_VALUE) ? safe_value_q :
    VAL_CLOSED;

  // Output selection; hold reuses the register so no extra copy is kept
  // Loop command passes raw: no clamp to the nominal sub-range
  assign value_d =
    force_closed ? VAL_CLOSED :
    force_open ? VAL_OPEN :
    force_hold ? value_q :
    use_fallback ? fallback_val :
    loop_cmd_in;

  // Limit comparison against the current output
  logic alarm_over;
  logic alarm_under;
  logic warn_over;
  logic warn_under;

  aola_limit_check u_alarm_check (
    .enable_in(alarm_en_q),
    .value_in(value_q),
    .trip_hi_in(alarm_hi_q),
    .trip_lo_in(alarm_lo_q),
    .over_out(alarm_over),
    .under_out(alarm_under)
  );

  aola_limit_check u_warn_check (
    .enable_in(warn_en_q),
    .value_in(value_q),
    .trip_hi_in(warn_hi_q),
    .trip_lo_in(warn_lo_q),
    .over_out(warn_over),
    .under_out(warn_under)
  );

  // Flags are a fresh level each cycle, not sticky
  assign flags_d = {4'h0, warn_under, warn_over, alarm_under, alarm_over};

  // Service decode
  wire inst_class = svc_instance_in == 8'h00;
  wire inst_one = svc_instance_in == 8'h01;
  wire is_get = svc_code_in == SVC_GET_SINGLE;
  wire is_set = svc_code_in == SVC_SET_SINGLE;
  wire attr_settable = svc_attr_in == ATTR_FORCE || svc_attr_in == ATTR_ALARM_EN ||
    svc_attr_in == ATTR_WARN_EN || svc_attr_in == ATTR_ALARM_HI ||
    svc_attr_in == ATTR_ALARM_LO || svc_attr_in == ATTR_WARN_HI ||
    svc_attr_in == ATTR_WARN_LO || svc_attr_in == ATTR_FALLBACK ||
    svc_attr_in == ATTR_SAFE_VALUE;
  wire attr_known = attr_settable || svc_attr_in == ATTR_DATA_TYPE ||
    svc_attr_in == ATTR_DATA_UNITS || svc_attr_in == ATTR_VALUE ||
    svc_attr_in == ATTR_FLAGS;
  // Fallback codes beyond 3 are refused; force codes are stored as given
  wire bad_value = svc_attr_in == ATTR_FALLBACK && svc_wdata_in[7:0] > FALL_SAFE_VALUE;

  // Instance read multiplexer
  wire [15:0] inst_rdata =
    (svc_attr_in == ATTR_DATA_TYPE) ? DATA_TYPE_CODE :
    (svc_attr_in == ATTR_DATA_UNITS) ? DATA_UNITS_CODE :
    (svc_attr_in == ATTR_FORCE) ? {8'h00, force_q} :
    (svc_attr_in == ATTR_VALUE) ? value_q :
    (svc_attr_in == ATTR_FLAGS) ? {8'h00, flags_q} :
    (svc_attr_in == ATTR_ALARM_EN) ? {15'h0000, alarm_en_q} :
    (svc_attr_in == ATTR_WARN_EN) ? {15'h0000, warn_en_q} :
    (svc_attr_in == ATTR_ALARM_HI) ? alarm_hi_q :
    (svc_attr_in == ATTR_ALARM_LO) ? alarm_lo_q :
    (svc_attr_in == ATTR_WARN_HI) ? warn_hi_q :
    (svc_attr_in == ATTR_WARN_LO) ? warn_lo_q :
    (svc_attr_in == ATTR_FALLBACK) ? {8'h00, fallback_q} :
    (svc_attr_in == ATTR_SAFE_VALUE) ? safe_value_q :
    16'h0000;

  // Status of the answer, first refusal wins
  wire [7:0] rsp_status_d =
    !(inst_class || inst_one) ? RSP_NO_OBJECT :
    !(is_get || (is_set && inst_one)) ? RSP_NO_SERVICE :
    inst_class ? ((svc_attr_in == ATTR_REVISION) ? RSP_OK : RSP_NO_ATTR) :
    !attr_known ? RSP_NO_ATTR :
    (is_set && !attr_settable) ? RSP_NOT_SETTABLE :
    (is_set && bad_value) ? RSP_BAD_VALUE :
    RSP_OK;
  wire rsp_ok = rsp_status_d == RSP_OK;
  wire [15:0] rsp_data_d = (!rsp_ok || is_set) ? 16'h0000 :
    inst_class ? REVISION : inst_rdata;
  // Write strobe for one accepted set
  wire wr = svc_valid_in && is_set && rsp_ok;
  wire wr_attr_force = wr && svc_attr_in == ATTR_FORCE;

  // Attribute storage; enables come up disabled
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      force_q <= FORCE_RST;
      fallback_q <= FALL_RST;
      safe_value_q <= SAFE_VALUE_RST;
      alarm_en_q <= 1'b0;
      warn_en_q <= 1'b0;
      alarm_hi_q <= VAL_MAX;
      alarm_lo_q <= VAL_MIN;
      warn_hi_q <= VAL_MAX;
      warn_lo_q <= VAL_MIN;
    end else if (wr) begin
      // Store the supplied value into the addressed attribute
      case (svc_attr_in)
        ATTR_FORCE: force_q <= svc_wdata_in[7:0];
        ATTR_FALLBACK: fallback_q <= svc_wdata_in[7:0];
        ATTR_SAFE_VALUE: safe_value_q <= svc_wdata_in;
        ATTR_ALARM_EN: alarm_en_q <= svc_wdata_in[0];
        ATTR_WARN_EN: warn_en_q <= svc_wdata_in[0];
        ATTR_ALARM_HI: alarm_hi_q <= svc_wdata_in;
        ATTR_ALARM_LO: alarm_lo_q <= svc_wdata_in;
        ATTR_WARN_HI: warn_hi_q <= svc_wdata_in;
        ATTR_WARN_LO: warn_lo_q <= svc_wdata_in;
        default: force_q <= force_q;
      endcase
    end
  end

  // Output value and flags; closed until the first edge
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      value_q <= VAL_CLOSED;
      flags_q <= 8'h00;
    end else begin
      value_q <= value_d;
      flags_q <= flags_d;
    end
  end

  // Exception forwarding to the supervisor
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      exc_alarm_q <= 1'b0;
      exc_alarm_det_q <= 2'h0;
      exc_warn_q <= 1'b0;
      exc_warn_det_q <= 2'h0;
    end else begin
      exc_alarm_det_q <= sup_alarm_en_in ? flags_q[1:0] : 2'h0;
      exc_alarm_q <= sup_alarm_en_in && (flags_q[1:0] != 2'h0);
      exc_warn_det_q <= sup_warn_en_in ? flags_q[3:2] : 2'h0;
      exc_warn_q <= sup_warn_en_in && (flags_q[3:2] != 2'h0);
    end
  end

  // One answer per request, the edge after it
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rsp_valid_q <= 1'b0;
      rsp_status_q <= RSP_OK;
      rsp_data_q <= 16'h0000;
    end else begin
      rsp_valid_q <= svc_valid_in;
      if (svc_valid_in) begin
        rsp_status_q <= rsp_status_d;
        rsp_data_q <= rsp_data_d;
      end
    end
  end

  assign actuator_value_out = value_q;
  assign limit_flags_out = flags_q;
  assign exc_alarm_out = exc_alarm_q;
  assign exc_alarm_detail_out = exc_alarm_det_q;
  assign exc_warn_out = exc_warn_q;
  assign exc_warn_detail_out = exc_warn_det_q;
  assign rsp_valid_out = rsp_valid_q;
  assign rsp_status_out = rsp_status_q;
  assign rsp_data_out = rsp_data_q;

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_normal_passes: assert property (
    force_q == FORCE_NORMAL && executing_in |=> value_q == $past(loop_cmd_in))
    else $error("normal mode did not pass loop command");
  a_closed_zero: assert property (
    force_q == FORCE_CLOSED |=> value_q == VAL_CLOSED)
    else $error("closed force not zero");
  a_open_full: assert property (
    force_q == FORCE_OPEN |=> value_q == VAL_OPEN)
    else $error("open force not full scale");
  a_hold_freezes: assert property (
    force_q == FORCE_HOLD ##1 force_q == FORCE_HOLD |-> $stable(value_q))
    else $error("hold did not freeze output");
  a_fallback_safe_val: assert property (
    force_q == FORCE_FALLBACK && fallback_q == FALL_SAFE_VALUE
    |=> value_q == $past(safe_value_q))
    else $error("safe value not driven");
  a_idle_fallback_closed: assert property (
    force_q == FORCE_NORMAL && !executing_in && fallback_q == FALL_CLOSED
    |=> value_q == VAL_CLOSED)
    else $error("idle fallback not closed");
  a_upper_flags_zero: assert property (
    limit_flags_out[7:4] == 4'h0)
    else $error("upper flag bits set");
  a_high_alarm_set: assert property (
    alarm_en_q && $signed(value_q) > $signed(alarm_hi_q) |=> limit_flags_out[FLAG_HI_ALARM])
    else $error("high alarm not set");
  a_flags_clear: assert property (
    !warn_en_q && !alarm_en_q |=> limit_flags_out == 8'h00)
    else $error("flags set while disabled");
  a_alarm_forward: assert property (
    sup_alarm_en_in && limit_flags_out[1:0] != 2'h0 |=> exc_alarm_out)
    else $error("alarm not forwarded");
  a_warn_forward: assert property (
    sup_warn_en_in && limit_flags_out[3:2] != 2'h0 |=> exc_warn_out)
    else $error("warning not forwarded");
  a_answer_next: assert property (
    svc_valid_in |=> rsp_valid_out ##1 !rsp_valid_out || $past(svc_valid_in))
    else $error("answer not one cycle after request");
  a_set_force_stores: assert property (
    wr_attr_force |=> force_q == $past(svc_wdata_in[7:0]))
    else $error("set did not store force code");

  c_force_open: cover property (force_q == FORCE_OPEN ##1 value_q == VAL_OPEN);
  c_hold_fallback: cover property (force_q == FORCE_FALLBACK && fallback_q == FALL_HOLD);
  c_alarm_forward: cover property (exc_alarm_out);
  c_set_ok: cover property (wr ##1 rsp_valid_out && rsp_status_out == RSP_OK);
endmodule

/* testbench/aola_master_model.sv */
`timescale 1ns/1ps
// Network master: one get or set request at a time
module aola_master_model (
  input wire logic clk_in,
  input wire logic rsp_valid_in,
  input wire logic [7:0] rsp_status_in,
  input wire logic [15:0] rsp_data_in,
  output logic svc_valid_out,
  output logic [7:0] svc_code_out,
  output logic [7:0] svc_instance_out,
  output logic [7:0] svc_attr_out,
  output logic [15:0] svc_wdata_out
);
  initial begin
    svc_valid_out = 1'b0;
    svc_code_out = 8'h00;
    svc_instance_out = 8'h00;
    svc_attr_out = 8'h00;
    svc_wdata_out = 16'h0000;
  end

  // Strobe for one taking edge, then wait a bounded time for the answer
  task automatic req(input logic [7:0] c, input logic [7:0] i, input logic [7:0] a,
                     input logic [15:0] d, output logic [7:0] st, output logic [15:0] rd);
    int n;
    st = 8'hFF; // Marker: no answer seen
    rd = 16'hFFFF;
    svc_valid_out = 1'b1;
    svc_code_out = c;
    svc_instance_out = i;
    svc_attr_out = a;
    svc_wdata_out = d;
    @(posedge clk_in);
    @(negedge clk_in);
    svc_valid_out = 1'b0;
    // Released code, attribute and data fields show junk so stale values cannot pass
    svc_code_out = ~c;
    svc_attr_out = ~a;
    svc_wdata_out = ~d;
    for (n = 0; n < 4; n++) begin
      if (rsp_valid_in === 1'b1) begin
        st = rsp_status_in;
        rd = rsp_data_in;
        break;
      end
      @(negedge clk_in);
    end
    // Let one edge pass so the next strobe never lands in this time step
    @(negedge clk_in);
  endtask
endmodule

/* testbench/aola_top_bench.sv */
`timescale 1ns/1ps
// Bench for the actuator selector and limit monitor
module aola_top_bench import aola_pkg::*;;
  typedef struct {
    logic [7:0] frc;
    logic [7:0] fb;
    logic ex;
    logic [15:0] cmd;
    logic [15:0] exp;
  } aola_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] cmd = 16'h0000;
  logic ex = 1'b0;
  logic sup_a = 1'b0;
  logic sup_w = 1'b0;
  logic sv;
  logic [7:0] sc, si, sa, rs, fl, st;
  logic [15:0] sw, rd, val, rdat;
  logic rv, ea, ew;
  logic [1:0] ead, ewd;
  int n_fail = 0;
  int cmp_count = 0;
  aola_row_t rows[8] = '{
    '{8'h00, 8'h00, 1'b1, 16'h1234, 16'h1234},
    '{8'h00, 8'h00, 1'b1, 16'h5000, 16'h5000},
    '{8'h01, 8'h01, 1'b1, 16'h1234, 16'h0000},
    '{8'h02, 8'h00, 1'b1, 16'h1234, 16'h6000},
    '{8'h04, 8'h00, 1'b1, 16'h1234, 16'h0000},
    '{8'h04, 8'h01, 1'b1, 16'h1234, 16'h6000},
    '{8'h04, 8'h03, 1'b1, 16'h1234, 16'h0ABC},
    '{8'h07, 8'h01, 1'b0, 16'h1234, 16'h6000}
  };

  aola_top dut_u (.ref_clk_in(clk), .arst_n_in(rst_n), .loop_cmd_in(cmd),
    .executing_in(ex), .sup_alarm_en_in(sup_a), .sup_warn_en_in(sup_w),
    .svc_valid_in(sv), .svc_code_in(sc), .svc_instance_in(si), .svc_attr_in(sa),
    .svc_wdata_in(sw), .rsp_valid_out(rv), .rsp_status_out(rs), .rsp_data_out(rdat),
    .actuator_value_out(val), .limit_flags_out(fl), .exc_alarm_out(ea),
    .exc_alarm_detail_out(ead), .exc_warn_out(ew), .exc_warn_detail_out(ewd));

  aola_master_model m_u (.clk_in(clk), .rsp_valid_in(rv), .rsp_status_in(rs),
    .rsp_data_in(rdat), .svc_valid_out(sv), .svc_code_out(sc), .svc_instance_out(si),
    .svc_attr_out(sa), .svc_wdata_out(sw));

  // Clock at 200 MHz
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Verdict in one place
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Let value, flags and exception stages settle
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  task automatic setv(input logic [7:0] a, input logic [15:0] d);
    m_u.req(SVC_SET_SINGLE, 8'h01, a, d, st, rd);
    chk("set status", {8'h00, RSP_OK}, {8'h00, st});
    chk("set data", 16'h0000, rd);
  endtask

  task automatic getv(input logic [7:0] i, input logic [7:0] a, input logic [15:0] e);
    m_u.req(SVC_GET_SINGLE, i, a, 16'h0000, st, rd);
    chk("get status", {8'h00, RSP_OK}, {8'h00, st});
    chk("get data", e, rd);
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    // Reset state of outputs and enables
    chk("value rst", 16'h0000, val);
    chk("flags rst", 16'h0000, {8'h00, fl});
    getv(8'h01, ATTR_ALARM_EN, 16'h0000);
    getv(8'h01, ATTR_WARN_EN, 16'h0000);
    getv(8'h00, ATTR_REVISION, 16'h0001);
    setv(ATTR_SAFE_VALUE, 16'h0ABC);
    // Ordinary selection cases
    foreach (rows[k]) begin
      setv(ATTR_FALLBACK, {8'h00, rows[k].fb});
      setv(ATTR_FORCE, {8'h00, rows[k].frc});
      cmd = rows[k].cmd;
      ex = rows[k].ex;
      settle();
      chk("value", rows[k].exp, val);
      getv(8'h01, ATTR_VALUE, rows[k].exp);
    end
    // Hold keeps the value from before the force code
    // Last row left the device idle, so go back to executing first
    setv(ATTR_FORCE, 16'h0000);
    ex = 1'b1;
    cmd = 16'h1111;
    settle();
    setv(ATTR_FORCE, {8'h00, FORCE_HOLD});
    cmd = 16'h2222;
    settle();
    chk("force hold", 16'h1111, val);
    // Fallback hold keeps the value from before leaving executing
    setv(ATTR_FORCE, 16'h0000);
    setv(ATTR_FALLBACK, {8'h00, FALL_HOLD});
    cmd = 16'h3333;
    settle();
    ex = 1'b0;
    cmd = 16'h4444;
    settle();
    chk("fallback hold", 16'h3333, val);
    // Limit flags and supervisor forwarding
    ex = 1'b1;
    cmd = 16'h2000;
    setv(ATTR_ALARM_HI, 16'h1000);
    settle();
    chk("flags disabled", 16'h0000, {8'h00, fl});
    setv(ATTR_ALARM_EN, 16'h0001);
    sup_a = 1'b1;
    settle();
    chk("hi alarm", 16'h0001, {8'h00, fl});
    chk("exc alarm", 16'h0003, {14'h0000, ea, ead[0]});
    setv(ATTR_WARN_LO, 16'h3000);
    setv(ATTR_WARN_EN, 16'h0001);
    sup_w = 1'b1;
    settle();
    chk("lo warn", 16'h0009, {8'h00, fl});
    chk("exc warn", 16'h0006, {13'h0000, ew, ewd});
    cmd = 16'h0800;
    setv(ATTR_ALARM_LO, 16'h0900);
    settle();
    chk("lo alarm", 16'h000A, {8'h00, fl});
    chk("exc lo alarm", 16'h0006, {13'h0000, ea, ead});
    setv(ATTR_ALARM_EN, 16'h0000);
    settle();
    chk("alarm off", 16'h0008, {8'h00, fl});
    chk("exc alarm off", 16'h0000, {13'h0000, ea, ead});
    getv(8'h01, ATTR_FLAGS, 16'h0008);
    // Read-only attribute refuses a set and keeps its value
    m_u.req(SVC_SET_SINGLE, 8'h01, ATTR_VALUE, 16'h1234, st, rd);
    chk("ro set", {8'h00, RSP_NOT_SETTABLE}, {8'h00, st});
    getv(8'h01, ATTR_VALUE, 16'h0800);
    // Refused requests answer with their status and change nothing
    m_u.req(SVC_GET_SINGLE, 8'h02, ATTR_VALUE, 16'h0000, st, rd);
    chk("no object", {8'h00, RSP_NO_OBJECT}, {8'h00, st});
    m_u.req(SVC_SET_SINGLE, 8'h00, ATTR_REVISION, 16'h0005, st, rd);
    chk("class set", {8'h00, RSP_NO_SERVICE}, {8'h00, st});
    m_u.req(8'h01, 8'h01, ATTR_VALUE, 16'h0000, st, rd);
    chk("bad service", {8'h00, RSP_NO_SERVICE}, {8'h00, st});
    m_u.req(SVC_GET_SINGLE, 8'h01, 8'h02, 16'h0000, st, rd);
    chk("no attr", {8'h00, RSP_NO_ATTR}, {8'h00, st});
    m_u.req(SVC_SET_SINGLE, 8'h01, ATTR_FALLBACK, 16'h0004, st, rd);
    chk("bad fallback", {8'h00, RSP_BAD_VALUE}, {8'h00, st});
    getv(8'h01, ATTR_FALLBACK, {8'h00, FALL_HOLD});
    // Reset in mid-run brings outputs and attributes back to defaults
    rst_n = 1'b0;
    @(negedge clk);
    chk("value mid rst", 16'h0000, val);
    chk("flags mid rst", 16'h0000, {8'h00, fl});
    chk("exc mid rst", 16'h0000, {12'h000, ea, ead, ew});
    rst_n = 1'b1;
    getv(8'h01, ATTR_ALARM_EN, 16'h0000);
    getv(8'h01, ATTR_WARN_EN, 16'h0000);
    getv(8'h01, ATTR_ALARM_HI, VAL_MAX);
    getv(8'h01, ATTR_VALUE, 16'h0800);
    stop_test();
  end
endmodule
